// >>> logic/onchip_expanded_onchip_ram_movx_router.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module onchip_expanded_onchip_ram_movx_router (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // CPU data access port
  input  wire logic        CPU_REQ,
  input  wire logic [2:0]  CPU_SPACE,
  input  wire logic        CPU_WRITE,
  input  wire logic [15:0] CPU_ADDR,
  input  wire logic [7:0]  CPU_WDATA,
  output logic             CPU_BUSY,
  output logic             CPU_DONE,
  output logic [7:0]       CPU_RDATA,
  // Special function register space
  output logic             SFR_REQ,
  output logic             SFR_WRITE,
  output logic [7:0]       SFR_ADDR,
  output logic [7:0]       SFR_WDATA,
  input  wire logic [7:0]  SFR_RDATA,
  // Straps and mode
  input  wire logic        SECURITY_EXT_SEL,
  input  wire logic        DOUBLE_SPEED,
  // External bus pins
  input  wire logic [7:0]  PORT0_IN,
  output logic [7:0]       PORT0_OUT,
  output logic             PORT0_OE,
  output logic [7:0]       PORT2_OUT,
  output logic             PORT2_OE,
  output logic             READ_STROBE_N,
  output logic             WRITE_STROBE_N,
  output logic             ADDR_LATCH,
  output logic             PULLUP_ENABLE
);

  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_SFR  = 3'h2,
    S_EXT  = 3'h4
  } st_t;

  typedef struct packed {
    st_t        st;
    // Control register fields
    logic       pullup_en;
    logic       stretch;
    logic [1:0] size;
    logic       ext_sel;
    logic       ale_sup;
    // Strap capture
    logic [1:0] strap_cnt;
    logic       strap_done;
    // Synchronisers
    logic [7:0] p0_s1;
    logic [7:0] p0_s2;
    logic       sec_s1;
    logic       sec_s2;
    logic       x2_s1;
    logic       x2_s2;
    // CPU answer
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic       last_ext;
    // Register space request
    logic       sfr_req;
    logic       sfr_write;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    // External cycle request
    logic        ext_start;
    logic        ext_write;
    logic        ext_use_hi;
    logic [15:0] ext_addr;
    logic [7:0]  ext_wdata;
    // APB answer
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } top_t;

  top_t s_r;
  top_t s_nxt;

  logic [7:0] iram [0:mem_router_pkg::IRAM_BYTES-1];
  logic [7:0] expanded_onchip_ram [0:mem_router_pkg::EXPANDED_ONCHIP_RAM_BYTES-1];

  logic       iram_we;
  logic [7:0] iram_wa;
  logic       expanded_onchip_ram_we;
  logic [9:0] expanded_onchip_ram_wa;
  logic [7:0] mem_wd;

  ext_bus_if eb ();

  ext_cycle_engine u_engine (
    .clk (CLOCK),
    .rst (RESET),
    .eb  (eb)
  );

  assign eb.start        = s_r.ext_start;
  assign eb.write        = s_r.ext_write;
  assign eb.use_hi       = s_r.ext_use_hi;
  assign eb.addr         = s_r.ext_addr;
  assign eb.wdata        = s_r.ext_wdata;
  assign eb.stretch      = s_r.stretch;
  assign eb.ale_suppress = s_r.ale_sup;
  assign eb.x2           = s_r.x2_s2;
  assign eb.p0_in        = s_r.p0_s2;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [7:0]  aux_rd;
    logic [7:0]  stat_rd;
    logic        access;
    // Defaults
    aux_rd  = 8'h00;
    stat_rd = 8'h00;
    access  = 1'b0;
    s_nxt   = s_r;
    iram_we = 1'b0;
    iram_wa = CPU_ADDR[7:0];
    expanded_onchip_ram_we = 1'b0;
    expanded_onchip_ram_wa = CPU_ADDR[9:0];
    mem_wd  = CPU_WDATA;

    s_nxt.p0_s1  = PORT0_IN;
    s_nxt.p0_s2  = s_r.p0_s1;
    s_nxt.sec_s1 = SECURITY_EXT_SEL;
    s_nxt.sec_s2 = s_r.sec_s1;
    s_nxt.x2_s1  = DOUBLE_SPEED;
    s_nxt.x2_s2  = s_r.x2_s1;

    // Strap is sampled only once the synchroniser holds a real value
    if (!s_r.strap_done) begin
      if (s_r.strap_cnt == mem_router_pkg::STRAP_WAIT) begin
        s_nxt.ext_sel    = s_r.sec_s2;
        s_nxt.strap_done = 1'b1;
      end else begin
        s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      end
    end

    // ---------------- APB ----------------
    aux_rd[mem_router_pkg::PULLUP_DIS_BIT] = ~s_r.pullup_en;
    aux_rd[mem_router_pkg::STRETCH_BIT]    = s_r.stretch;
    aux_rd[mem_router_pkg::SIZE_HI_BIT]    = s_r.size[1];
    aux_rd[mem_router_pkg::SIZE_LO_BIT]    = s_r.size[0];
    aux_rd[mem_router_pkg::EXT_SEL_BIT]    = s_r.ext_sel;
    aux_rd[mem_router_pkg::ALE_SUP_BIT]    = s_r.ale_sup;
    stat_rd[mem_router_pkg::ST_BUSY_BIT]   = s_r.busy;
    stat_rd[mem_router_pkg::ST_EXT_BIT]    = s_r.last_ext;
    stat_rd[mem_router_pkg::ST_LOAD_BIT]   = s_r.strap_done;

    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    access = PSEL && PENABLE;
    if (access && !s_r.pready) begin
      // One wait state, answer registered
      s_nxt.pready = 1'b1;
      case (PADDR)
        mem_router_pkg::AUX_ADDR:    s_nxt.prdata = {24'h000000, aux_rd};
        mem_router_pkg::STATUS_ADDR: s_nxt.prdata = {24'h000000, stat_rd};
        default: begin
          s_nxt.prdata  = 32'h00000000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (access && s_r.pready && PWRITE && PADDR == mem_router_pkg::AUX_ADDR) begin
      // Reserved bits are dropped on write and read back as zero
      s_nxt.pullup_en  = ~PWDATA[mem_router_pkg::PULLUP_DIS_BIT];
      s_nxt.stretch    = PWDATA[mem_router_pkg::STRETCH_BIT];
      s_nxt.size       = {PWDATA[mem_router_pkg::SIZE_HI_BIT],
                          PWDATA[mem_router_pkg::SIZE_LO_BIT]};
      s_nxt.ext_sel    = PWDATA[mem_router_pkg::EXT_SEL_BIT];
      s_nxt.ale_sup    = PWDATA[mem_router_pkg::ALE_SUP_BIT];
    end

    // ---------------- CPU accesses ----------------
    s_nxt.done      = 1'b0;
    s_nxt.sfr_req   = 1'b0;
    s_nxt.ext_start = 1'b0;
    case (s_r.st)
      S_IDLE: begin
        if (CPU_REQ) begin
          s_nxt.done     = 1'b1;
          s_nxt.last_ext = 1'b0;
          case (CPU_SPACE)
            mem_router_pkg::SP_DIRECT: begin
              if (CPU_ADDR[7:0] > mem_router_pkg::LOWER_LAST) begin
                // Register space; answer comes a cycle later
                s_nxt.done      = 1'b0;
                s_nxt.busy      = 1'b1;
                s_nxt.st        = S_SFR;
                s_nxt.sfr_req   = 1'b1;
                s_nxt.sfr_write = CPU_WRITE;
                s_nxt.sfr_addr  = CPU_ADDR[7:0];
                s_nxt.sfr_wdata = CPU_WDATA;
              end else begin
                iram_we     = CPU_WRITE;
                s_nxt.rdata = iram[CPU_ADDR[7:0]];
              end
            end
            mem_router_pkg::SP_INDIRECT,
            mem_router_pkg::SP_STACK: begin
              // Full 256 bytes, upper half is RAM not registers
              iram_we     = CPU_WRITE;
              s_nxt.rdata = iram[CPU_ADDR[7:0]];
            end
            mem_router_pkg::SP_MOVX_IDX: begin
              if (s_r.ext_sel) begin
                s_nxt.done       = 1'b0;
                s_nxt.busy       = 1'b1;
                s_nxt.st         = S_EXT;
                s_nxt.last_ext   = 1'b1;
                s_nxt.ext_start  = 1'b1;
                s_nxt.ext_write  = CPU_WRITE;
                s_nxt.ext_use_hi = 1'b0;
                s_nxt.ext_addr   = {8'h00, CPU_ADDR[7:0]};
                s_nxt.ext_wdata  = CPU_WDATA;
              end else begin
                // Index form never reaches past the first page
                expanded_onchip_ram_wa     = {2'b00, CPU_ADDR[7:0]};
                expanded_onchip_ram_we     = CPU_WRITE;
                s_nxt.rdata = expanded_onchip_ram[{2'b00, CPU_ADDR[7:0]}];
              end
            end
            mem_router_pkg::SP_MOVX_PTR: begin
              if (!s_r.ext_sel &&
                  CPU_ADDR <= mem_router_pkg::size_limit(s_r.size)) begin
                expanded_onchip_ram_we     = CPU_WRITE;
                s_nxt.rdata = expanded_onchip_ram[CPU_ADDR[9:0]];
              end else begin
                s_nxt.done       = 1'b0;
                s_nxt.busy       = 1'b1;
                s_nxt.st         = S_EXT;
                s_nxt.last_ext   = 1'b1;
                s_nxt.ext_start  = 1'b1;
                s_nxt.ext_write  = CPU_WRITE;
                s_nxt.ext_use_hi = 1'b1;
                s_nxt.ext_addr   = CPU_ADDR;
                s_nxt.ext_wdata  = CPU_WDATA;
              end
            end
            default: begin
              s_nxt.rdata = 8'h00;
            end
          endcase
          if (CPU_WRITE)
            s_nxt.rdata = 8'h00;
        end
      end
      S_SFR: begin
        s_nxt.st    = S_IDLE;
        s_nxt.busy  = 1'b0;
        s_nxt.done  = 1'b1;
        s_nxt.rdata = s_r.sfr_write ? 8'h00 : SFR_RDATA;
      end
      S_EXT: begin
        if (eb.done) begin
          s_nxt.st    = S_IDLE;
          s_nxt.busy  = 1'b0;
          s_nxt.done  = 1'b1;
          s_nxt.rdata = s_r.ext_write ? 8'h00 : eb.rdata;
        end
      end
      default: begin
        s_nxt.st   = S_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      s_r    <= '0;
      s_r.st <= S_IDLE;
      {s_r.pullup_en, s_r.stretch, s_r.size, s_r.ext_sel, s_r.ale_sup} <=
        {~mem_router_pkg::AUX_RESET[7], mem_router_pkg::AUX_RESET[5],
         mem_router_pkg::AUX_RESET[3:0]};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Memories carry no reset, contents are undefined at power-up
  always_ff @(posedge CLOCK) begin
    if (iram_we)
      iram[iram_wa] <= mem_wd;
    if (expanded_onchip_ram_we)
      expanded_onchip_ram[expanded_onchip_ram_wa] <= mem_wd;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign PRDATA         = s_r.prdata;
  assign PREADY         = s_r.pready;
  assign PSLVERR        = s_r.pslverr;
  assign CPU_BUSY       = s_r.busy;
  assign CPU_DONE       = s_r.done;
  assign CPU_RDATA      = s_r.rdata;
  assign SFR_REQ        = s_r.sfr_req;
  assign SFR_WRITE      = s_r.sfr_write;
  assign SFR_ADDR       = s_r.sfr_addr;
  assign SFR_WDATA      = s_r.sfr_wdata;
  assign PORT0_OUT      = eb.p0_out;
  assign PORT0_OE       = eb.p0_oe;
  assign PORT2_OUT      = eb.p2_out;
  assign PORT2_OE       = eb.p2_oe;
  assign READ_STROBE_N  = eb.rd_n;
  assign WRITE_STROBE_N = eb.wr_n;
  assign ADDR_LATCH     = eb.ale;
  // Port latches themselves live outside; stored inverted so the pin is a flop
  assign PULLUP_ENABLE  = s_r.pullup_en;
endmodule

// >>> inc/mem_router_pkg.sv
package mem_router_pkg;
  // Register map, index times four gives the byte address
  localparam logic [11:0] AUX_INDEX    = 12'h08E;
  localparam logic [11:0] STATUS_INDEX = 12'h08F;
  localparam logic [11:0] AUX_ADDR     = {AUX_INDEX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR  = {STATUS_INDEX[9:0], 2'b00};
  // Control field positions
  localparam int PULLUP_DIS_BIT = 7;
  localparam int STRETCH_BIT    = 5;
  localparam int SIZE_HI_BIT    = 3;
  localparam int SIZE_LO_BIT    = 2;
  localparam int EXT_SEL_BIT    = 1;
  localparam int ALE_SUP_BIT    = 0;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EXT_BIT  = 1;
  localparam int ST_LOAD_BIT = 2;
  // Memory map
  localparam logic [15:0] EXPANDED_ONCHIP_RAM_LAST  = 16'h03FF;
  localparam logic [7:0]  LOWER_LAST = 8'h7F;
  localparam int          IRAM_BYTES = 256;
  localparam int          EXPANDED_ONCHIP_RAM_BYTES = 1024;
  // Timing in clock periods
  localparam logic [4:0] STROBE_SHORT = 5'h06;
  localparam logic [4:0] STROBE_LONG  = 5'h1E;
  localparam logic [2:0] ALE_DIV_STD  = 3'h6;
  localparam logic [2:0] ALE_DIV_X2   = 3'h3;
  localparam logic [1:0] STRAP_WAIT   = 2'h2;

  typedef enum logic [2:0] {
    SP_DIRECT    = 3'h0,
    SP_INDIRECT  = 3'h1,
    SP_MOVX_IDX  = 3'h2,
    SP_MOVX_PTR  = 3'h3,
    SP_STACK     = 3'h4
  } space_t;

  function automatic logic [15:0] size_limit(input logic [1:0] sel);
    size_limit = {6'h00, sel, 8'hFF};
  endfunction
endpackage

// >>> inc/ext_bus_if.sv
`timescale 1ns/1ps
interface ext_bus_if;
  logic        start;
  logic        write;
  logic        use_hi;
  logic        stretch;
  logic        ale_suppress;
  logic        x2;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  p0_in;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  p0_out;
  logic        p0_oe;
  logic [7:0]  p2_out;
  logic        p2_oe;
  logic        rd_n;
  logic        wr_n;
  logic        ale;

  modport ctrl (
    output start, write, use_hi, stretch, ale_suppress, x2, addr, wdata, p0_in,
    input  done, rdata, p0_out, p0_oe, p2_out, p2_oe, rd_n, wr_n, ale
  );
  modport engine (
    input  start, write, use_hi, stretch, ale_suppress, x2, addr, wdata, p0_in,
    output done, rdata, p0_out, p0_oe, p2_out, p2_oe, rd_n, wr_n, ale
  );
endinterface

// >>> logic/ext_cycle_engine.sv
`timescale 1ns/1ps
module ext_cycle_engine (
  input  wire logic   clk,
  input  wire logic   rst,
  ext_bus_if.engine   eb
);
  typedef enum logic [3:0] {
    E_IDLE   = 4'h1,
    E_LATCH  = 4'h2,
    E_STROBE = 4'h4,
    E_HOLD   = 4'h8
  } est_t;

  typedef struct packed {
    est_t       st;
    logic [4:0] cnt;
    logic [2:0] ale_cnt;
    logic       write;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;
    logic [7:0] p0_out;
    logic       p0_oe;
    logic [7:0] p2_out;
    logic       p2_oe;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
  } eng_t;

  eng_t s_r;
  eng_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ale  = 1'b0;
    // Free-running latch pulse, only while the bus is idle
    if (s_r.ale_cnt == 3'h0)
      s_nxt.ale_cnt = (eb.x2 ? mem_router_pkg::ALE_DIV_X2 : mem_router_pkg::ALE_DIV_STD) - 3'h1;
    else
      s_nxt.ale_cnt = s_r.ale_cnt - 3'h1;
    case (s_r.st)
      E_IDLE: begin
        if (eb.start) begin
          s_nxt.st     = E_LATCH;
          s_nxt.write  = eb.write;
          s_nxt.wdata  = eb.wdata;
          s_nxt.ale    = 1'b1;
          s_nxt.p0_out = eb.addr[7:0];
          s_nxt.p0_oe  = 1'b1;
          s_nxt.p2_out = eb.addr[15:8];
          s_nxt.p2_oe  = eb.use_hi;
          s_nxt.cnt    = (eb.stretch ? mem_router_pkg::STROBE_LONG
                                     : mem_router_pkg::STROBE_SHORT) - 5'h01;
        end else if (!eb.ale_suppress && s_r.ale_cnt == 3'h0) begin
          s_nxt.ale = 1'b1;
        end
      end
      E_LATCH: begin
        s_nxt.st = E_STROBE;
        if (s_r.write) begin
          s_nxt.p0_out = s_r.wdata;
          s_nxt.wr_n   = 1'b0;
        end else begin
          s_nxt.p0_oe = 1'b0;
          s_nxt.rd_n  = 1'b0;
        end
      end
      E_STROBE: begin
        if (s_r.cnt == 5'h00) begin
          s_nxt.st    = E_HOLD;
          s_nxt.rd_n  = 1'b1;
          s_nxt.wr_n  = 1'b1;
          s_nxt.rdata = eb.p0_in;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      E_HOLD: begin
        s_nxt.st    = E_IDLE;
        s_nxt.p0_oe = 1'b0;
        s_nxt.p2_oe = 1'b0;
        s_nxt.done  = 1'b1;
      end
      default: s_nxt.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r      <= '0;
      s_r.st   <= E_IDLE;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign eb.done   = s_r.done;
  assign eb.rdata  = s_r.rdata;
  assign eb.p0_out = s_r.p0_out;
  assign eb.p0_oe  = s_r.p0_oe;
  assign eb.p2_out = s_r.p2_out;
  assign eb.p2_oe  = s_r.p2_oe;
  assign eb.rd_n   = s_r.rd_n;
  assign eb.wr_n   = s_r.wr_n;
  assign eb.ale    = s_r.ale;
endmodule

// >>> tb/ext_mem_model.sv
`timescale 1ns/1ps
// ==========
// External memory on the multiplexed bus
module ext_mem_model (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p2_out,
  input  wire logic       p2_oe,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic [7:0]      drive
);
  logic [7:0] mem [0:255];
  logic [7:0] adr;
  logic [7:0] last;
  initial begin
    adr = 8'h00;
    last = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
  end
  // Folded address keeps the model small; both bytes still matter
  always @(posedge clk) begin
    if (ale) adr <= p0_out ^ (p2_oe ? p2_out : 8'h00);
    if (!wr_n) mem[adr] <= p0_out;
    if (!rd_n) last <= mem[adr];
  end
  // Released bus shows the inverse so stale data never passes as a read
  assign drive = rd_n ? ~last : mem[adr];
endmodule

// >>> tb/router_asserts.sv
`timescale 1ns/1ps
// ==========
// Port checks of the memory router
module router_asserts (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        CPU_REQ,
  input wire logic [2:0]  CPU_SPACE,
  input wire logic [15:0] CPU_ADDR,
  input wire logic        CPU_BUSY,
  input wire logic        CPU_DONE,
  input wire logic        SFR_REQ,
  input wire logic [7:0]  SFR_ADDR,
  input wire logic        PORT0_OE,
  input wire logic        PORT2_OE,
  input wire logic [7:0]  PORT2_OUT,
  input wire logic        READ_STROBE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        ADDR_LATCH,
  input wire logic        PULLUP_ENABLE
);
  logic       take;
  logic [7:0] aux_r;
  logic [4:0] low_cnt_r;
  logic [2:0] space_r;
  logic [7:0] hi_r;
  assign take = CPU_REQ && !CPU_BUSY;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      aux_r <= 8'h00;
      low_cnt_r <= 5'h00;
      space_r <= 3'h0;
      hi_r <= 8'h00;
    end else begin
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == mem_router_pkg::AUX_ADDR) aux_r <= PWDATA[7:0];
      low_cnt_r <= (READ_STROBE_N && WRITE_STROBE_N) ? 5'h00 : low_cnt_r + 5'h01;
      if (take) space_r <= CPU_SPACE;
      if (take) hi_r <= CPU_ADDR[15:8];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // ==========
  // Assertions
  a_strobe_excl: assert property (READ_STROBE_N || WRITE_STROBE_N)
    else $error("both strobes low");
  a_strobe_width: assert property ($rose(READ_STROBE_N && WRITE_STROBE_N) |->
    low_cnt_r == (aux_r[5] ? mem_router_pkg::STROBE_LONG : mem_router_pkg::STROBE_SHORT)) else $error("strobe width");
  a_sfr_route: assert property (take && CPU_SPACE == 3'h0 && CPU_ADDR[7:0] > 8'h7F |=>
    SFR_REQ && SFR_ADDR == $past(CPU_ADDR[7:0])) else $error("direct high not to sfr");
  a_lower_direct: assert property (take && CPU_SPACE == 3'h0 && CPU_ADDR[7:0] <= 8'h7F |=>
    CPU_DONE && !SFR_REQ) else $error("direct low not to ram");
  a_indirect_ram: assert property (take && CPU_SPACE == 3'h1 |=> CPU_DONE && !SFR_REQ)
    else $error("indirect not to ram");
  a_stack_internal: assert property (take && CPU_SPACE == 3'h4 |=> CPU_DONE && !PORT0_OE)
    else $error("stack left iram");
  a_onchip_quiet: assert property (take && CPU_SPACE == 3'h2 && !aux_r[1] |=>
    CPU_DONE && READ_STROBE_N && WRITE_STROBE_N && !PORT0_OE) else $error("on-chip move touched pins");
  a_ptr_miss: assert property (take && CPU_SPACE == 3'h3 && CPU_ADDR > {6'h00, aux_r[3:2], 8'hFF} |=>
    CPU_BUSY && !CPU_DONE) else $error("hidden address served on chip");
  a_port2_ptr: assert property (PORT2_OE |-> space_r == 3'h3)
    else $error("port two driven outside pointer move");
  a_port2_high: assert property (ADDR_LATCH && PORT2_OE |-> PORT2_OUT == hi_r)
    else $error("port two high byte");
  a_pullup_level: assert property (PULLUP_ENABLE == !aux_r[7])
    else $error("pull-up level");
  a_latch_quiet: assert property (aux_r[0] && $past(aux_r[0]) && !CPU_BUSY |-> !ADDR_LATCH)
    else $error("latch pulse while suppressed");
  a_apb_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("apb answer late");
  c_stretched: cover property ($rose(READ_STROBE_N && WRITE_STROBE_N) && aux_r[5]);
  c_sfr: cover property (SFR_REQ);
  c_ptr_ext: cover property (ADDR_LATCH && PORT2_OE);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench for the memory router
module testbench;
  logic        CLOCK, RESET, PSEL, PENABLE, PWRITE, CPU_REQ, CPU_WRITE, SECURITY_EXT_SEL, DOUBLE_SPEED;
  logic        PREADY, PSLVERR, CPU_BUSY, CPU_DONE, SFR_REQ, SFR_WRITE, PORT0_OE, PORT2_OE, err;
  logic        READ_STROBE_N, WRITE_STROBE_N, ADDR_LATCH, PULLUP_ENABLE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, prd;
  logic [2:0]  CPU_SPACE;
  logic [15:0] CPU_ADDR;
  logic [7:0]  CPU_WDATA, CPU_RDATA, SFR_ADDR, SFR_WDATA, SFR_RDATA, PORT0_IN, PORT0_OUT, PORT2_OUT, ext_drv, rd;
  int          error_cnt, tests_run, ale_cnt;
  onchip_expanded_onchip_ram_movx_router onchip_expanded_onchip_ram_movx_router_inst (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CPU_REQ(CPU_REQ), .CPU_SPACE(CPU_SPACE), .CPU_WRITE(CPU_WRITE), .CPU_ADDR(CPU_ADDR),
    .CPU_WDATA(CPU_WDATA), .CPU_BUSY(CPU_BUSY), .CPU_DONE(CPU_DONE), .CPU_RDATA(CPU_RDATA), .SFR_REQ(SFR_REQ),
    .SFR_WRITE(SFR_WRITE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .SECURITY_EXT_SEL(SECURITY_EXT_SEL), .DOUBLE_SPEED(DOUBLE_SPEED), .PORT0_IN(PORT0_IN), .PORT0_OUT(PORT0_OUT),
    .PORT0_OE(PORT0_OE), .PORT2_OUT(PORT2_OUT), .PORT2_OE(PORT2_OE), .READ_STROBE_N(READ_STROBE_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .ADDR_LATCH(ADDR_LATCH), .PULLUP_ENABLE(PULLUP_ENABLE));
  ext_mem_model ext_mem_model_inst (.clk(CLOCK), .ale(ADDR_LATCH), .p0_out(PORT0_OUT), .p2_out(PORT2_OUT),
    .p2_oe(PORT2_OE), .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N), .drive(ext_drv));
  assign SFR_RDATA = SFR_ADDR ^ 8'h5A;
  assign PORT0_IN = PORT0_OE ? PORT0_OUT : ext_drv;
  always @(negedge CLOCK) if (ADDR_LATCH === 1'b1) ale_cnt++;
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // ==========
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    prd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 50) error_cnt++;
    if (n == 50) report_and_stop();
    @(posedge CLOCK);
  endtask
  task automatic cpu(input logic [2:0] sp, input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    CPU_REQ <= 1'b1;
    CPU_SPACE <= sp;
    CPU_WRITE <= w;
    CPU_ADDR <= a;
    CPU_WDATA <= d;
    @(posedge CLOCK);
    CPU_REQ <= 1'b0;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (CPU_DONE !== 1'b1 && n < 200);
    rd = CPU_RDATA;
    if (n == 200) error_cnt++;
    if (n == 200) report_and_stop();
    @(posedge CLOCK);
  endtask
  // ==========
  // Main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, CPU_REQ, CPU_WRITE, SECURITY_EXT_SEL, DOUBLE_SPEED} = 7'h00;
    {PADDR, PWDATA, CPU_SPACE, CPU_ADDR, CPU_WDATA} = 71'h0;
    {error_cnt, tests_run, ale_cnt} = {32'h0, 32'h0, 32'h0};
    RESET = 1'b1;
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLOCK);
    apb(1'b0, mem_router_pkg::AUX_ADDR, 32'h0);
    chk("control reset", 32'h00, prd);
    apb(1'b0, mem_router_pkg::STATUS_ADDR, 32'h0);
    chk("strap loaded", 32'h4, prd & 32'h4);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped refused", 32'h1, {31'h0, err});
    cpu(3'h0, 1'b1, 16'h0010, 8'h11);
    cpu(3'h1, 1'b0, 16'h0010, 8'h00);
    chk("lower ram", 8'h11, rd);
    cpu(3'h1, 1'b1, 16'h0090, 8'h22);
    cpu(3'h0, 1'b0, 16'h0090, 8'h00);
    chk("sfr read", 8'hCA, rd);
    cpu(3'h0, 1'b1, 16'h00A0, 8'h55);
    chk("sfr write", 9'h155, {SFR_WRITE, SFR_WDATA});
    cpu(3'h1, 1'b0, 16'h0090, 8'h00);
    chk("upper ram", 8'h22, rd);
    cpu(3'h4, 1'b1, 16'h0091, 8'h33);
    cpu(3'h2, 1'b1, 16'h0091, 8'h44);
    cpu(3'h1, 1'b0, 16'h0091, 8'h00);
    chk("stack in iram", 8'h33, rd);
    cpu(3'h3, 1'b1, 16'h0120, 8'h66);
    chk("hidden to bus", 8'h66, ext_mem_model_inst.mem[8'h21]);
    apb(1'b1, mem_router_pkg::AUX_ADDR, 32'h0C);
    cpu(3'h3, 1'b1, 16'h0320, 8'h77);
    cpu(3'h2, 1'b1, 16'h0320, 8'h88);
    cpu(3'h3, 1'b0, 16'h0320, 8'h00);
    chk("expanded_onchip_ram top", 8'h77, rd);
    chk("bus untouched", 8'hE0, ext_mem_model_inst.mem[8'h23]);
    cpu(3'h3, 1'b0, 16'h0020, 8'h00);
    chk("index form", 8'h88, rd);
    cpu(3'h3, 1'b0, 16'h0400, 8'h00);
    chk("past expanded_onchip_ram end", 8'hC7, rd);
    apb(1'b1, mem_router_pkg::AUX_ADDR, 32'h22);
    cpu(3'h2, 1'b1, 16'h0044, 8'h99);
    chk("index bus write", 8'h99, ext_mem_model_inst.mem[8'h44]);
    cpu(3'h3, 1'b0, 16'h1244, 8'h00);
    chk("pointer bus read", 8'h95, rd);
    apb(1'b1, mem_router_pkg::AUX_ADDR, 32'h02);
    cpu(3'h3, 1'b0, 16'h0005, 8'h00);
    chk("short read", 8'hC6, rd);
    apb(1'b1, mem_router_pkg::AUX_ADDR, 32'h80);
    @(negedge CLOCK);
    chk("pullups off", 32'h0, {31'h0, PULLUP_ENABLE});
    ale_cnt = 0;
    repeat (24) @(posedge CLOCK);
    chk("latch rate", 32'd4, ale_cnt);
    DOUBLE_SPEED <= 1'b1;
    repeat (8) @(posedge CLOCK);
    ale_cnt = 0;
    repeat (24) @(posedge CLOCK);
    chk("latch rate x2", 32'd8, ale_cnt);
    apb(1'b1, mem_router_pkg::AUX_ADDR, 32'h01);
    repeat (2) @(posedge CLOCK);
    ale_cnt = 0;
    repeat (24) @(posedge CLOCK);
    cpu(3'h3, 1'b0, 16'h0400, 8'h00);
    chk("latch only in moves", 32'd1, ale_cnt);
    report_and_stop();
  end
endmodule
bind onchip_expanded_onchip_ram_movx_router router_asserts router_asserts_inst (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .CPU_REQ(CPU_REQ),
  .CPU_SPACE(CPU_SPACE), .CPU_ADDR(CPU_ADDR), .CPU_BUSY(CPU_BUSY), .CPU_DONE(CPU_DONE), .SFR_REQ(SFR_REQ),
  .SFR_ADDR(SFR_ADDR), .PORT0_OE(PORT0_OE), .PORT2_OE(PORT2_OE), .PORT2_OUT(PORT2_OUT),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .ADDR_LATCH(ADDR_LATCH),
  .PULLUP_ENABLE(PULLUP_ENABLE));
